// *** logic/hsq_sequencer.sv ***
// Host power button sequencer: button timing, I2C command target,
// power and indicator sequencing. Button and I2C pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none

module hsq_sequencer #(
  parameter int TICK_CYCLES = hsq_pkg::MS_CYCLES,
  parameter int HOLD_REBOOT_MS = hsq_pkg::HOLD_REBOOT_MS,
  parameter int HOLD_SHUT_MS = hsq_pkg::HOLD_SHUT_MS,
  parameter int HOLD_FORCE_MS = hsq_pkg::HOLD_FORCE_MS,
  parameter int SHUT_DELAY_MS = hsq_pkg::SHUT_DELAY_MS,
  parameter int REMOTE_DELAY_MS = hsq_pkg::REMOTE_DELAY_MS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_btn_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_host_pwr,
  output logic o_shdn,
  output hsq_pkg::hsq_led_s o_led
);
  import hsq_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [MS_W-1:0] L_RBT = MS_W'(HOLD_REBOOT_MS);
  localparam logic [MS_W-1:0] L_SHUT = MS_W'(HOLD_SHUT_MS);
  localparam logic [MS_W-1:0] L_FORCE = MS_W'(HOLD_FORCE_MS);
  localparam logic [MS_W-1:0] L_SDLY = MS_W'(SHUT_DELAY_MS);
  localparam logic [MS_W-1:0] L_RDLY = MS_W'(REMOTE_DELAY_MS);
  localparam logic [MS_W-1:0] L_FAST = MS_W'(ALIVE_FLASH_MS - 1);
  localparam logic [MS_W-1:0] L_SLOW = MS_W'(SLOW_PULSE_MS - 1);
  localparam logic [MS_W-1:0] L_PULSE = MS_W'(SHDN_PULSE_MS);
  localparam logic [MS_W-1:0] L_NFL = MS_W'(ALIVE_FLASHES);

  if (TICK_CYCLES < 4 || HOLD_REBOOT_MS >= HOLD_SHUT_MS || HOLD_SHUT_MS >= HOLD_FORCE_MS ||
      HOLD_FORCE_MS >= 2 ** MS_W - 1 || SHUT_DELAY_MS >= 2 ** MS_W ||
      REMOTE_DELAY_MS >= 2 ** MS_W) begin : g_chk
    $error("hsq_sequencer: parameter out of range");
  end

  function automatic logic in_win(input logic [MS_W-1:0] c, input logic [MS_W-1:0] lo,
                                  input logic [MS_W-1:0] hi);
    in_win = (c > lo) && (c < hi);
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic btn_s1_r, btn_s2_r, scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r, scl_q_r, sda_q_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {btn_s1_r, btn_s2_r, scl_s1_r, scl_s2_r} <= 4'hF;
      {sda_s1_r, sda_s2_r, scl_q_r, sda_q_r} <= 4'hF;
    end else begin
      btn_s1_r <= i_btn_n;
      btn_s2_r <= btn_s1_r;
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      scl_q_r <= scl_s2_r;
      sda_q_r <= sda_s2_r;
    end
  end

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [PW-1:0] pre_cnt_r;
  logic ms_tick_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (pre_cnt_r == PW'(TICK_CYCLES - 1));
      pre_cnt_r <= (pre_cnt_r == PW'(TICK_CYCLES - 1)) ? '0 : pre_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Button hold timing
  // ----------------------------------------
  logic btn_lvl, btn_q_r;
  logic [MS_W-1:0] hold_cnt_r;

  hsq_debounce #(.DB_TICKS(DEBOUNCE_MS)) u_db (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(ms_tick_r),
    .i_raw(~btn_s2_r),
    .o_level(btn_lvl)
  );

  wire press_edge = btn_lvl && !btn_q_r;
  wire release_edge = !btn_lvl && btn_q_r;
  wire force_evt = btn_lvl && ms_tick_r && hold_cnt_r == L_FORCE;
  wire reboot_req = release_edge && in_win(hold_cnt_r, L_RBT, L_SHUT);
  wire shut_req = release_edge && in_win(hold_cnt_r, L_SHUT, L_FORCE + 1'b1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      btn_q_r <= 1'b0;
      hold_cnt_r <= '0;
    end else begin
      btn_q_r <= btn_lvl;
      if (press_edge) begin
        hold_cnt_r <= '0;
      end else if (btn_lvl && ms_tick_r && hold_cnt_r != '1) begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // I2C target, write-only commands
  // ----------------------------------------
  logic i2c_act_r, addr_ph_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  hsq_cmd_s cmd_r;

  wire scl_rise = scl_s2_r && !scl_q_r;
  wire scl_fall = !scl_s2_r && scl_q_r;
  wire i2c_start = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r;
  wire i2c_stop = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      i2c_act_r <= 1'b0;
      addr_ph_r <= 1'b0;
      bit_cnt_r <= '0;
      shift_r <= '0;
      o_sda_oe <= 1'b0;
      o_sda_o <= 1'b0;
      cmd_r <= '0;
    end else begin
      cmd_r <= '0;
      if (i2c_start) begin
        i2c_act_r <= 1'b1;
        addr_ph_r <= 1'b1;
        bit_cnt_r <= '0;
        o_sda_oe <= 1'b0;
      end else if (i2c_stop) begin
        i2c_act_r <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (i2c_act_r && scl_rise && !o_sda_oe) begin
        shift_r <= {shift_r[6:0], sda_s2_r};
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end else if (i2c_act_r && scl_fall) begin
        if (o_sda_oe) begin
          o_sda_oe <= 1'b0;
          bit_cnt_r <= '0;
          addr_ph_r <= 1'b0;
        end else if (bit_cnt_r == BITS_PER_BYTE) begin
          if (!addr_ph_r) begin
            o_sda_oe <= 1'b1;
            cmd_r.ready <= (shift_r == CMD_READY);
            cmd_r.ready_off <= (shift_r == CMD_READY_OFF);
          end else if (shift_r == {I2C_ADDR, 1'b0}) begin
            o_sda_oe <= 1'b1;
          end else begin
            i2c_act_r <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Power sequencing
  // ----------------------------------------
  hsq_state_e state_r;
  logic [MS_W-1:0] timer_r;

  wire go_reboot = state_r == ST_RUN && !force_evt && reboot_req;
  wire timer_on = state_r == ST_SHUT_DLY || state_r == ST_REMOTE;
  logic [MS_W-1:0] fast_cnt_r, slow_cnt_r, alive_cnt_r, pulse_cnt_r;
  logic fast_ph_r, slow_ph_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= ST_ALIVE;
    end else if (force_evt && state_r != ST_ALIVE) begin
      state_r <= ST_OFF;
    end else begin
      unique case (state_r)
        ST_ALIVE: if (alive_cnt_r == L_NFL) state_r <= ST_OFF;
        ST_OFF: if (press_edge) state_r <= ST_BOOT;
        ST_BOOT: if (cmd_r.ready) state_r <= ST_RUN;
        ST_RUN: begin
          if (reboot_req) begin
            state_r <= ST_RBT_REQ;
          end else if (shut_req) begin
            state_r <= ST_SHUT_REQ;
          end else if (cmd_r.ready_off) begin
            state_r <= ST_REMOTE;
          end
        end
        ST_RBT_REQ: if (cmd_r.ready_off) state_r <= ST_RBT_WAIT;
        ST_RBT_WAIT: if (cmd_r.ready) state_r <= ST_RUN;
        ST_SHUT_REQ: if (cmd_r.ready_off) state_r <= ST_SHUT_DLY;
        ST_SHUT_DLY: if (timer_r == L_SDLY) state_r <= ST_OFF;
        ST_REMOTE: begin
          if (cmd_r.ready) begin
            state_r <= ST_RUN;
          end else if (timer_r == L_RDLY) begin
            state_r <= ST_OFF;
          end
        end
        default: state_r <= ST_ALIVE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !timer_on) begin
      timer_r <= '0;
    end else if (ms_tick_r && timer_r != '1) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Indicator patterns and shutdown pulse
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fast_cnt_r <= '0;
      slow_cnt_r <= '0;
      fast_ph_r <= 1'b0;
      slow_ph_r <= 1'b0;
      alive_cnt_r <= '0;
    end else if (ms_tick_r) begin
      fast_cnt_r <= (fast_cnt_r == L_FAST) ? '0 : fast_cnt_r + 1'b1;
      slow_cnt_r <= (slow_cnt_r == L_SLOW) ? '0 : slow_cnt_r + 1'b1;
      if (fast_cnt_r == L_FAST) begin
        fast_ph_r <= !fast_ph_r;
        if (state_r == ST_ALIVE && alive_cnt_r != L_NFL) alive_cnt_r <= alive_cnt_r + 1'b1;
      end
      if (slow_cnt_r == L_SLOW) slow_ph_r <= !slow_ph_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_cnt_r <= '0;
    end else if (go_reboot) begin
      pulse_cnt_r <= L_PULSE;
    end else if (ms_tick_r && pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  wire dim_on = pre_cnt_r < PW'(TICK_CYCLES / DIM_DIV);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_led <= '0;
      o_host_pwr <= 1'b0;
      o_shdn <= 1'b0;
    end else begin
      o_host_pwr <= !(state_r == ST_ALIVE || state_r == ST_OFF);
      o_shdn <= pulse_cnt_r != '0 || state_r == ST_SHUT_REQ || state_r == ST_SHUT_DLY;
      unique case (state_r)
        ST_ALIVE: o_led <= '{pwr: fast_ph_r, rdy: !fast_ph_r};
        ST_OFF: o_led <= '0;
        ST_BOOT, ST_RBT_WAIT, ST_REMOTE: o_led <= '{pwr: slow_ph_r, rdy: 1'b0};
        ST_RUN: o_led <= '{pwr: 1'b1, rdy: 1'b1};
        ST_RBT_REQ, ST_SHUT_REQ: o_led <= '{pwr: dim_on, rdy: 1'b1};
        ST_SHUT_DLY: o_led <= '{pwr: dim_on, rdy: 1'b0};
        default: o_led <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic shdn_q_r, shdn_seen_r;

  always_ff @(posedge i_clk) begin
    if (i_rst || state_r == ST_RUN) begin
      shdn_q_r <= 1'b0;
      shdn_seen_r <= 1'b0;
    end else begin
      shdn_q_r <= o_shdn;
      if (o_shdn && !shdn_q_r) shdn_seen_r <= 1'b1;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_alive;
    state_r == ST_ALIVE |=> o_led.pwr != o_led.rdy;
  endproperty
  a_alive: assert property (p_alive) else $error("alive flash not alternating");

  property p_boot;
    state_r == ST_OFF && press_edge && !force_evt |=> state_r == ST_BOOT ##1 o_host_pwr;
  endproperty
  a_boot: assert property (p_boot) else $error("press did not power host");

  property p_ready;
    state_r == ST_BOOT && cmd_r.ready && !force_evt |=> ##1 o_led.pwr && o_led.rdy;
  endproperty
  a_ready: assert property (p_ready) else $error("ready did not light indicators");

  property p_reboot;
    go_reboot |=> state_r == ST_RBT_REQ ##1 o_shdn;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot hold not classified");

  property p_shdn_once;
    (state_r == ST_RBT_REQ || state_r == ST_RBT_WAIT) && o_shdn && !shdn_q_r |-> !shdn_seen_r;
  endproperty
  a_shdn_once: assert property (p_shdn_once) else $error("second reboot pulse");

  property p_rbt_back;
    state_r == ST_RBT_WAIT && cmd_r.ready && !force_evt |=> ##1 o_led.pwr && o_led.rdy;
  endproperty
  a_rbt_back: assert property (p_rbt_back) else $error("reboot did not resume");

  property p_shut;
    state_r == ST_RUN && shut_req && !force_evt |=> state_r == ST_SHUT_REQ ##1 o_shdn [*2];
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown request not held");

  property p_sdly;
    state_r == ST_SHUT_DLY && !force_evt && timer_r < L_SDLY |=> o_host_pwr && state_r == ST_SHUT_DLY;
  endproperty
  a_sdly: assert property (p_sdly) else $error("power removed before delay");

  property p_force;
    force_evt && state_r != ST_ALIVE |=> ##1 !o_host_pwr;
  endproperty
  a_force: assert property (p_force) else $error("forced off failed");

  property p_remote;
    state_r == ST_REMOTE && !cmd_r.ready && !force_evt && timer_r == L_RDLY |=> ##1 !o_host_pwr;
  endproperty
  a_remote: assert property (p_remote) else $error("remote wait expiry kept power");

  property p_ack;
    i2c_act_r && addr_ph_r && scl_fall && !o_sda_oe && !i2c_start && !i2c_stop &&
      bit_cnt_r == BITS_PER_BYTE && shift_r == {I2C_ADDR, 1'b0} |=> o_sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("own address not acknowledged");

  property p_ignore;
    state_r == ST_OFF && !press_edge |=> state_r == ST_OFF;
  endproperty
  a_ignore: assert property (p_ignore) else $error("command acted on while off");

  c_boot: cover property (state_r == ST_BOOT ##1 state_r == ST_RUN);
  c_rbt: cover property (state_r == ST_RBT_WAIT ##1 state_r == ST_RUN);
  c_shut: cover property (state_r == ST_SHUT_DLY ##1 state_r == ST_OFF);
  c_remote: cover property (state_r == ST_REMOTE ##1 state_r == ST_OFF);

endmodule

`default_nettype wire

// *** logic/hsq_pkg.sv ***
// Constants and types for the host power button sequencer.
// Assumes one 200 MHz clock and a synchronous active-high reset.

package hsq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_REBOOT_MS = 500;
  localparam int HOLD_SHUT_MS = 3000;
  localparam int HOLD_FORCE_MS = 10_000;
  localparam int SHUT_DELAY_MS = 10_000;
  localparam int REMOTE_DELAY_MS = 30_000;
  localparam int DEBOUNCE_MS = 10;
  localparam int ALIVE_FLASH_MS = 100;
  localparam int ALIVE_FLASHES = 10;
  localparam int SLOW_PULSE_MS = 500;
  localparam int SHDN_PULSE_MS = 200;
  localparam int DIM_DIV = 4;
  localparam int MS_W = 16;

  // ----------------------------------------
  // I2C target
  // ----------------------------------------
  localparam logic [6:0] I2C_ADDR = 7'h5A;
  localparam logic [7:0] CMD_READY = 8'h01;
  localparam logic [7:0] CMD_READY_OFF = 8'h02;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic pwr;
    logic rdy;
  } hsq_led_s;

  typedef struct packed {
    logic ready;
    logic ready_off;
  } hsq_cmd_s;

  typedef enum logic [3:0] {
    ST_ALIVE,
    ST_OFF,
    ST_BOOT,
    ST_RUN,
    ST_RBT_REQ,
    ST_RBT_WAIT,
    ST_SHUT_REQ,
    ST_SHUT_DLY,
    ST_REMOTE
  } hsq_state_e;

endpackage

// *** logic/hsq_debounce.sv ***
// Button debouncer counting millisecond ticks.
// Assumes the raw input is already synchronised to i_clk.
`timescale 1ns/10ps
`default_nettype none

module hsq_debounce #(
  parameter int DB_TICKS = hsq_pkg::DEBOUNCE_MS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_raw,
  output logic o_level
);
  import hsq_pkg::*;

  localparam int CW = $clog2(DB_TICKS + 1);

  logic [CW-1:0] cnt_r;

  if (DB_TICKS < 1) begin : g_chk
    $error("hsq_debounce: DB_TICKS must be at least 1");
  end

  // ----------------------------------------
  // Level changes only after a stable run
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
      o_level <= 1'b0;
    end else if (i_raw == o_level) begin
      cnt_r <= '0;
    end else if (i_tick) begin
      if (cnt_r == CW'(DB_TICKS - 1)) begin
        o_level <= i_raw;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/hsq_host_model.sv ***
// Host-side model: I2C controller that sends sequencer commands, and a
// timer on the shutdown line. Assumes SDA is a pulled-up wired-AND line.
`timescale 1ns/10ps
`default_nettype none

module hsq_host_model #(
  parameter int PHASE = 8
) (
  input wire logic i_clk,
  input wire logic i_sda,
  input wire logic i_shdn,
  output logic o_scl,
  output logic o_sda_low
);
  import hsq_pkg::*;

  int shdn_rises = 0;
  int shdn_len = 0;
  logic shdn_q = 1'b0;

  // ----------------------------------------
  // Shutdown line timer: counts pulses and cycles high
  // ----------------------------------------
  always @(posedge i_clk) begin
    shdn_q <= i_shdn;
    if (i_shdn && !shdn_q) begin
      shdn_rises <= shdn_rises + 1;
      shdn_len <= 1;
    end else if (i_shdn) begin
      shdn_len <= shdn_len + 1;
    end
  end

  task automatic clear_stats();
    shdn_rises = 0;
    shdn_len = 0;
  endtask

  // ----------------------------------------
  // I2C controller
  // ----------------------------------------
  task automatic wait_phase();
    repeat (PHASE) @(posedge i_clk);
    #1;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_low = !b[i];
      wait_phase();
      o_scl = 1'b1;
      wait_phase();
      o_scl = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
    end
    // Release SDA so the target can acknowledge
    o_sda_low = 1'b0;
    wait_phase();
    o_scl = 1'b1;
    wait_phase();
    ack = (i_sda === 1'b0);
    o_scl = 1'b0;
    wait_phase();
  endtask

  task automatic send_cmd(input logic [7:0] addr_b, input logic [7:0] cmd, output logic acked);
    logic a1;
    logic a2;
    a2 = 1'b0;
    o_sda_low = 1'b1;
    wait_phase();
    o_scl = 1'b0;
    wait_phase();
    send_byte(addr_b, a1);
    if (a1) begin
      send_byte(cmd, a2);
    end
    o_sda_low = 1'b1;
    wait_phase();
    o_scl = 1'b1;
    wait_phase();
    o_sda_low = 1'b0;
    wait_phase();
    acked = a1 && a2;
  endtask

  task automatic ready(output logic acked);
    send_cmd({I2C_ADDR, 1'b0}, CMD_READY, acked);
  endtask

  task automatic ready_off(output logic acked);
    send_cmd({I2C_ADDR, 1'b0}, CMD_READY_OFF, acked);
  endtask

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the power button sequencer.
// Assumes shortened timing parameters and the host model on I2C.
`timescale 1ns/10ps
`default_nettype none

module tb;
  import hsq_pkg::*;

  localparam int TICK = 10;
  localparam int SHUT_DLY = 20;
  localparam int REM_DLY = 80;

  logic i_clk;
  logic i_rst;
  logic i_btn_n;
  logic o_sda_o;
  logic o_sda_oe;
  logic o_host_pwr;
  logic o_shdn;
  hsq_led_s o_led;
  logic scl;
  logic host_sda_low;
  wire sda;
  logic ack;
  logic pwr_q;
  int bad_count;
  int n_checks;
  int pwr_chg;

  // Wired-AND line with pull-up: low while the host pulls or the target drives a zero
  assign sda = !host_sda_low && !(o_sda_oe && !o_sda_o);

  hsq_sequencer #(.TICK_CYCLES(TICK), .HOLD_REBOOT_MS(15), .HOLD_SHUT_MS(30), .HOLD_FORCE_MS(100),
    .SHUT_DELAY_MS(SHUT_DLY), .REMOTE_DELAY_MS(REM_DLY)) i_hsq_sequencer (
    .i_clk(i_clk), .i_rst(i_rst), .i_btn_n(i_btn_n), .i_scl(scl), .i_sda(sda),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_host_pwr(o_host_pwr), .o_shdn(o_shdn), .o_led(o_led));

  hsq_host_model i_hsq_host_model (
    .i_clk(i_clk), .i_sda(sda), .i_shdn(o_shdn), .o_scl(scl), .o_sda_low(host_sda_low));

  always #2.5 i_clk = ~i_clk;

  // Counts every change of the power indicator
  always @(posedge i_clk) begin
    pwr_q <= o_led.pwr;
    if (o_led.pwr !== pwr_q) begin
      pwr_chg++;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n * TICK) @(posedge i_clk);
    #1;
  endtask

  task automatic press(input int n);
    i_btn_n = 1'b0;
    tick(n);
    i_btn_n = 1'b1;
    tick(20);
  endtask

  task automatic boot();
    press(15);
    i_hsq_host_model.ready(ack);
    chk("boot_led", o_led, 2'h3);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_alive();
    press(20);
    chk("alive_pwr", o_host_pwr, 1'h0);
    chk("alive_alt", o_led.pwr ^ o_led.rdy, 1'h1);
    pwr_chg = 0;
    tick(400);
    chk("alive_toggles", pwr_chg >= 3, 1'h1);
    tick(700);
    i_hsq_host_model.ready(ack);
    chk("off_ack", ack, 1'h1);
    chk("off_ready_ignored", {o_host_pwr, o_led.rdy}, 2'h0);
    i_hsq_host_model.send_cmd(8'hB6, CMD_READY, ack);
    chk("wrong_addr_nack", ack, 1'h0);
  endtask

  task automatic sc_boot();
    press(15);
    chk("boot_pwr", o_host_pwr, 1'h1);
    chk("boot_rdy", o_led.rdy, 1'h0);
    pwr_chg = 0;
    tick(600);
    chk("boot_slow_pulse", pwr_chg >= 1 && pwr_chg <= 3, 1'h1);
    i_hsq_host_model.ready(ack);
    chk("run_led", o_led, 2'h3);
    i_hsq_host_model.ready(ack);
    chk("run_ready_again", o_led, 2'h3);
  endtask

  task automatic sc_reboot();
    i_hsq_host_model.clear_stats();
    press(12);
    chk("short_hold_none", i_hsq_host_model.shdn_rises, 0);
    press(20);
    pwr_chg = 0;
    tick(50);
    chk("rbt_dim", pwr_chg >= 2, 1'h1);
    chk("rbt_rdy", o_led.rdy, 1'h1);
    tick(200);
    chk("rbt_one_pulse", i_hsq_host_model.shdn_rises, 1);
    chk("rbt_len", i_hsq_host_model.shdn_len >= 1990 && i_hsq_host_model.shdn_len <= 2010, 1'h1);
    i_hsq_host_model.ready_off(ack);
    chk("rbt_wait", {o_host_pwr, o_led.rdy}, 2'h2);
    pwr_chg = 0;
    tick(600);
    chk("rbt_blink", pwr_chg >= 1, 1'h1);
    i_hsq_host_model.ready(ack);
    chk("rbt_back", o_led, 2'h3);
  endtask

  task automatic sc_shutdown();
    i_hsq_host_model.clear_stats();
    press(50);
    tick(100);
    chk("shut_held", {o_shdn, o_led.rdy}, 2'h3);
    chk("shut_one_rise", i_hsq_host_model.shdn_rises, 1);
    i_hsq_host_model.ready_off(ack);
    chk("shut_rdy_off", o_led.rdy, 1'h0);
    tick(SHUT_DLY - 10);
    chk("shut_delay_on", {o_host_pwr, o_shdn}, 2'h3);
    tick(10);
    chk("shut_off", o_host_pwr, 1'h0);
    i_hsq_host_model.ready(ack);
    chk("off_ready_ignored2", {o_host_pwr, o_led.rdy}, 2'h0);
  endtask

  task automatic sc_remote();
    boot();
    i_hsq_host_model.ready_off(ack);
    chk("rem_wait", {o_host_pwr, o_led.rdy}, 2'h2);
    tick(30);
    i_hsq_host_model.ready(ack);
    chk("rem_kept", {o_host_pwr, o_led}, 3'h7);
    i_hsq_host_model.ready_off(ack);
    tick(REM_DLY - 10);
    chk("rem_still_on", o_host_pwr, 1'h1);
    tick(10);
    chk("rem_expired", o_host_pwr, 1'h0);
  endtask

  task automatic sc_force();
    boot();
    i_btn_n = 1'b0;
    tick(95);
    chk("force_not_yet", o_host_pwr, 1'h1);
    tick(25);
    chk("force_off_held", o_host_pwr, 1'h0);
    i_btn_n = 1'b1;
    tick(20);
    chk("force_release_ignored", o_host_pwr, 1'h0);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_btn_n = 1'b1;
    bad_count = 0;
    n_checks = 0;
    pwr_chg = 0;
    repeat (5) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    sc_alive();
    sc_boot();
    sc_reboot();
    sc_shutdown();
    sc_remote();
    sc_force();
    report_and_stop();
  end

  initial begin
    #400_000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
